// ---- src/rfb_buffer.sv ----
// top of the 1:2 registered fanout buffer
// Contract
// RQ1 - thirteen bit registers each drive an A copy and a B copy that always carry the same value.
// RQ2 - out of reset, each data bit is captured when the true clock rises as the complementary clock falls.
// RQ3 - out of reset and with no such crossing, every output keeps its level and data is ignored.
// RQ4 - a low reset clears all registers and forces every output low whatever the other inputs do.
// RQ5 - while reset is low the data and clock receivers are off so no input reaches the registers.
// RQ6 - the controller holds all data inputs low for at least 22 ns after reset is released.
// RQ7 - the controller keeps data and clocks at valid levels for at least 22 ns after reset goes low.
// RQ8 - the first crossing after reset release loads the data, with no extra warm-up cycles.
`timescale 1ns/1ps
`include "rfb_params.svh"
module rfb_buffer #(
  parameter int NUM_BITS = `RFB_NUM_BITS
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ck_t,
  input wire logic i_ck_c,
  input wire logic [NUM_BITS-1:0] i_data_in_bits,
  output logic [NUM_BITS-1:0] o_registered_out_bits_a,
  output logic [NUM_BITS-1:0] o_registered_out_bits_b
);
  rfb_pkg::rfb_clk_pair_t clk_cur;
  rfb_pkg::rfb_clk_pair_t prev_q;
  rfb_pkg::rfb_clk_pair_t prev_d;
  logic [NUM_BITS-1:0] data_rcv;
  logic crossing;

  // receivers gated by reset: nothing toggles inside while it is low
  always_comb begin
    clk_cur.ck_t = i_ck_t & i_rst_n; // see RQ5
    clk_cur.ck_c = i_ck_c & i_rst_n; // see RQ5
    data_rcv = i_data_in_bits & {NUM_BITS{i_rst_n}}; // see RQ5
  end

  // history parks at a level pair that cannot look like a crossing, so the
  // release of reset never fakes one; a clock already high at release needs a full cycle
  always_comb begin
    prev_d = clk_cur;
    if (!i_rst_n) begin
      prev_d.ck_t = `RFB_TRUE_CLK_IDLE;
      prev_d.ck_c = `RFB_COMP_CLK_IDLE;
    end
  end

  always_ff @(posedge i_mclk) begin
    prev_q <= prev_d;
  end

  // no warm-up qualifier: the first clean crossing after release already loads
  assign crossing = i_rst_n & rfb_pkg::rfb_crossing(prev_q, clk_cur); // see RQ2 RQ8

  genvar g;
  generate
    for (g = 0; g < NUM_BITS; g++) begin : g_bit
      rfb_bit_slice u_slice (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_capture(crossing),
        .i_data_in_bit(data_rcv[g]),
        .o_out_a(o_registered_out_bits_a[g]),
        .o_out_b(o_registered_out_bits_b[g])
      );
    end
  endgenerate

  // helper: cycles since reset release, saturating
  localparam int ACT_CYC = `RFB_INPUT_ACTIVE_CYC;
  logic [7:0] since_rel_q;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      since_rel_q <= 8'h00;
    end else if (since_rel_q != 8'hFF) begin
      since_rel_q <= since_rel_q + 8'h01;
    end
  end

  property p_copies_equal;
    @(posedge i_mclk) o_registered_out_bits_a == o_registered_out_bits_b;
  endproperty
  a_copies_equal: assert property (p_copies_equal) else $error("A and B copies differ"); // see RQ1

  property p_capture;
    @(posedge i_mclk) disable iff (!i_rst_n)
    crossing ##1 i_rst_n |-> o_registered_out_bits_a == $past(i_data_in_bits);
  endproperty
  a_capture: assert property (p_capture) else $error("crossing did not load data"); // see RQ2

  property p_hold;
    @(posedge i_mclk) disable iff (!i_rst_n)
    !crossing ##1 i_rst_n |-> $stable(o_registered_out_bits_a) && $stable(o_registered_out_bits_b);
  endproperty
  a_hold: assert property (p_hold) else $error("outputs moved without a crossing"); // see RQ3

  property p_reset_low;
    @(posedge i_mclk) !i_rst_n |-> o_registered_out_bits_a == '0 && o_registered_out_bits_b == '0;
  endproperty
  a_reset_low: assert property (p_reset_low) else $error("outputs not low in reset"); // see RQ4

  property p_rcv_off;
    @(posedge i_mclk) !i_rst_n ##1 (i_rst_n && !crossing) |-> !crossing && o_registered_out_bits_a == '0;
  endproperty
  a_rcv_off: assert property (p_rcv_off) else $error("input reached registers during reset"); // see RQ5

  property p_first_load;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (since_rel_q < 8'h10 && crossing && $past(o_registered_out_bits_a) == '0) ##1 i_rst_n
      |-> o_registered_out_bits_b == $past(i_data_in_bits);
  endproperty
  a_first_load: assert property (p_first_load) else $error("first crossing after reset not loaded"); // see RQ8

  c_capture_ones: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
    crossing ##1 o_registered_out_bits_a == {NUM_BITS{1'b1}});
  c_reset_clear: cover property (@(posedge i_mclk)
    o_registered_out_bits_a != '0 ##1 !i_rst_n);
  c_late_capture: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
    crossing && since_rel_q >= 8'(ACT_CYC));
endmodule

// ---- src/rfb_params.svh ----
// constants of the registered fanout buffer
`ifndef RFB_PARAMS_SVH
`define RFB_PARAMS_SVH
`define RFB_NUM_BITS 13
`define RFB_CLK_PERIOD_PS 4000
`define RFB_INPUT_ACTIVE_TIME_NS 22
`define RFB_INPUT_INACTIVE_TIME_NS 22
`define RFB_INPUT_ACTIVE_CYC ((`RFB_INPUT_ACTIVE_TIME_NS * 1000 + `RFB_CLK_PERIOD_PS - 1) / `RFB_CLK_PERIOD_PS)
`define RFB_INPUT_INACTIVE_CYC ((`RFB_INPUT_INACTIVE_TIME_NS * 1000 + `RFB_CLK_PERIOD_PS - 1) / `RFB_CLK_PERIOD_PS)
`define RFB_BIT_RESET 1'h0
`define RFB_TRUE_CLK_IDLE 1'h1
`define RFB_COMP_CLK_IDLE 1'h0
`endif

// ---- src/rfb_pkg.sv ----
// types of the registered fanout buffer
package rfb_pkg;
  // sampled true and complementary clock levels
  typedef struct packed {
    logic ck_t;
    logic ck_c;
  } rfb_clk_pair_t;

  function automatic logic rfb_crossing(input rfb_clk_pair_t prev, input rfb_clk_pair_t cur);
    rfb_crossing = cur.ck_t & ~prev.ck_t & ~cur.ck_c & prev.ck_c;
  endfunction
endpackage

// ---- src/rfb_bit_slice.sv ----
// one captured bit driving its A and B copies
`timescale 1ns/1ps
`include "rfb_params.svh"
module rfb_bit_slice (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_capture,
  input wire logic i_data_in_bit,
  output logic o_out_a,
  output logic o_out_b
);
  logic a_q;
  logic a_d;
  logic b_q;
  logic b_d;

  // two flops per bit, as two output drivers would have; both load together
  always_comb begin
    a_d = a_q; // see RQ3
    b_d = b_q; // see RQ3
    if (!i_rst_n) begin
      a_d = `RFB_BIT_RESET; // see RQ4
      b_d = `RFB_BIT_RESET; // see RQ4
    end else if (i_capture) begin
      a_d = i_data_in_bit; // see RQ2
      b_d = i_data_in_bit; // see RQ1
    end
  end

  always_ff @(posedge i_mclk) begin
    a_q <= a_d;
    b_q <= b_d;
  end

  // reset forces the pins low at once, without waiting for the clock edge
  assign o_out_a = a_q & i_rst_n; // see RQ4
  assign o_out_b = b_q & i_rst_n; // see RQ4
endmodule

// ---- tb/rfb_ctrl_model.sv ----
// controller model driving the clock pair and the data bits
`timescale 1ns/1ps
`include "rfb_params.svh"
module rfb_ctrl_model (
  input wire logic i_mclk,
  output logic o_ck_t,
  output logic o_ck_c,
  output logic [`RFB_NUM_BITS-1:0] o_data
);
  // levels never float, the pair parks between frames
  initial begin
    o_ck_t = 1'h1;
    o_ck_c = 1'h0;
    o_data = 13'h0000;
  end
  // data must sit low around reset release so the receivers wake on a quiet bus
  task automatic park;
    @(posedge i_mclk);
    o_data <= '0;
  endtask
  // one crossing; data is then flipped so stale values are caught
  task automatic send(input logic [`RFB_NUM_BITS-1:0] d);
    @(posedge i_mclk);
    o_ck_t <= 1'h0;
    o_ck_c <= 1'h1;
    @(posedge i_mclk);
    o_ck_t <= 1'h1;
    o_ck_c <= 1'h0;
    o_data <= d;
    @(posedge i_mclk);
    o_data <= ~d;
  endtask
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench of the registered fanout buffer
`timescale 1ns/1ps
`include "rfb_params.svh"
module tb_top;
  logic i_mclk = 1'h0;
  logic i_rst_n = 1'h0;
  logic ck_t;
  logic ck_c;
  logic [12:0] din;
  logic [12:0] q_a;
  logic [12:0] q_b;
  logic [12:0] pats [4] = '{13'h1FFF, 13'h0000, 13'h0A5A, 13'h15A5};
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;
  initial forever #2 i_mclk = ~i_mclk;
  rfb_ctrl_model i_ctl (.i_mclk(i_mclk), .o_ck_t(ck_t), .o_ck_c(ck_c), .o_data(din));
  rfb_buffer i_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ck_t(ck_t), .i_ck_c(ck_c),
    .i_data_in_bits(din), .o_registered_out_bits_a(q_a), .o_registered_out_bits_b(q_b));
  task automatic chk(input logic [25:0] seen, input logic [25:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // crossings inside reset must not load; outputs stay low
  task automatic t_reset(input logic [12:0] d);
    i_ctl.send(13'h1FFF);
    #1 chk({q_a, q_b}, 26'h0);
    i_ctl.park();
    @(posedge i_mclk) i_rst_n <= 1'h1;
    repeat (`RFB_INPUT_ACTIVE_CYC) @(posedge i_mclk);
    #1 chk({q_a, q_b}, 26'h0);
    i_ctl.send(d);
    #1 chk({q_a, q_b}, {d, d});
    $display("test reset done");
  endtask
  // each pattern loads both copies, then holds while data moves
  task automatic t_capture;
    foreach (pats[i]) begin
      i_ctl.send(pats[i]);
      #1 chk({q_a, q_b}, {pats[i], pats[i]});
      repeat (4) @(posedge i_mclk);
      #1 chk({q_a, q_b}, {pats[i], pats[i]});
    end
    $display("test capture done");
  endtask
  // reset in mid-run clears at once, without a clock crossing
  task automatic t_midreset;
    i_ctl.send(13'h1555);
    @(posedge i_mclk) i_rst_n <= 1'h0;
    #1 chk({q_a, q_b}, 26'h0);
    repeat (`RFB_INPUT_INACTIVE_CYC) @(posedge i_mclk);
    $display("test midreset done");
  endtask
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 400) begin
      errors++;
      end_sim();
    end
  end
  initial begin
    repeat (5) @(posedge i_mclk);
    t_reset(13'h0F0F);
    t_capture();
    t_midreset();
    t_reset(13'h1E1E);
    end_sim();
  end
endmodule
